// File: rtl/i2c_slave_map.svh
// constants for the two-wire register slave: addresses, codes, filter lengths
// assumes inclusion by the package; the design files that need them do not include it
`ifndef I2C_SLAVE_MAP_SVH
`define I2C_SLAVE_MAP_SVH
`define SLAVE_ADDR        7'h48
`define GENERAL_CALL      8'h00
`define HS_CODE_HI        5'h01
`define FILT_SLOW_CYCLES  4'h4
`define FILT_FAST_CYCLES  4'h1
`define PTR_RESET         8'h00
`endif

// File: rtl/i2c_slave_pkg.sv
// types shared by the two-wire register slave and its input filter
// assumes the map header is on the include path
`include "i2c_slave_map.svh"
package i2c_slave_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_PTR,
		ST_WDATA,
		ST_RDATA,
		ST_MACK
	} phase_t;

	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_wr_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} line_t;
endpackage : i2c_slave_pkg

// File: rtl/line_filter.sv
// glitch filter on synchronised scl/sda; length set by speed mode
// assumes inputs already passed two flip-flops on mclk
`timescale 1ns/100ps
module line_filter
	import i2c_slave_pkg::*;
(
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire logic                 hs_mode,
	input  wire i2c_slave_pkg::line_t raw,
	output      i2c_slave_pkg::line_t clean
);
	typedef struct packed {
		line_t      out;
		logic [3:0] cnt_scl;
		logic [3:0] cnt_sda;
	} filt_t;

	filt_t st;
	filt_t next_st;
	logic [3:0] limit;

	always_comb begin
		limit = hs_mode ? `FILT_FAST_CYCLES : `FILT_SLOW_CYCLES;
		next_st = st;
		if (raw.scl == st.out.scl)
			next_st.cnt_scl = 4'h0;
		else if (st.cnt_scl + 4'h1 >= limit) begin
			next_st.out.scl = raw.scl;
			next_st.cnt_scl = 4'h0;
		end else
			next_st.cnt_scl = st.cnt_scl + 4'h1;
		if (raw.sda == st.out.sda)
			next_st.cnt_sda = 4'h0;
		else if (st.cnt_sda + 4'h1 >= limit) begin
			next_st.out.sda = raw.sda;
			next_st.cnt_sda = 4'h0;
		end else
			next_st.cnt_sda = st.cnt_sda + 4'h1;
	end

	always_ff @(posedge mclk) begin
		if (rst)
			st <= '{out: '{scl: 1'b1, sda: 1'b1}, cnt_scl: 4'h0, cnt_sda: 4'h0};
		else
			st <= next_st;
	end

	assign clean = st.out;
endmodule : line_filter

// File: rtl/i2c_reg_slave.sv
// two-wire slave giving a bus master byte access to 8-bit registers
// assumes scl/sda come from pins; register storage lives outside
`timescale 1ns/100ps
// How it works
// R1 - answer only address 0x48; write byte 0x90, read byte 0x91
// R2 - never drive scl low; no clock stretching at all
// R3 - all-zero general call byte is left unacknowledged
// R4 - same protocol at every rate up to 1MHz
// R5 - filters set to slow mode at reset and after each stop
// R6 - high-speed master code switches the filters to fast mode
// R7 - byte 0000_1xxx is not acknowledged; fast mode holds until stop
// R8 - start, write address, pointer byte; both acknowledged
// R9 - acknowledge write data, commit it on next sda rising edge
// R10 - further write bytes go to successive registers
// R11 - final ack or nack on a write leaves written data intact
// R12 - repeated start keeps the filter setting
// R13 - read address after repeated start; send pointed register's byte
// R14 - master ends single read with nack then stop or restart
// R15 - keep sending while master acks; release on nack
// R16 - stop leaves the register pointer unchanged
// R17 - eight bits msb first, then one acknowledge bit
// R18 - every pointer value is acknowledged
// R19 - after stop or wrong address, ignore scl until next start
// R20 - pointer steps by one after each data byte
module i2c_reg_slave
	import i2c_slave_pkg::*;
(
	input  wire logic                   mclk,
	input  wire logic                   rst,
	input  wire logic                   scl_in,
	input  wire logic                   sda_in,
	output      logic                   scl_out,
	output      logic                   scl_oe,
	output      logic                   sda_out,
	output      logic                   sda_oe,
	output      i2c_slave_pkg::reg_wr_t reg_wr,
	output      logic [7:0]             reg_rd_addr,
	input  wire logic [7:0]             reg_rd_data,
	output      logic                   hs_mode
);
	typedef struct packed {
		line_t      sync1;
		line_t      sync2;
		line_t      prev;
		phase_t     phase;
		logic [3:0] bitn;
		logic [7:0] shreg;
		logic [7:0] ptr;
		logic       rd;
		logic       ack_drv;
		logic       wr_pend;
		logic [7:0] wr_data;
		logic [7:0] wr_addr;
		reg_wr_t    wr;
		logic       hs;
		logic       sda_o;
	} slv_t;

	slv_t  st;
	slv_t  next_st;
	line_t clean;
	logic  start_det;
	logic  stop_det;
	logic  scl_rise;
	logic  scl_fall;
	logic  sda_rise;

	function automatic logic is_hs_code(input logic [7:0] b);
		is_hs_code = (b[7:3] == `HS_CODE_HI);
	endfunction : is_hs_code

	line_filter u_filt (
		.mclk    (mclk),
		.rst     (rst),
		.hs_mode (st.hs), // R4
		.raw     (st.sync2),
		.clean   (clean)
	);

	always_comb begin
		start_det = st.prev.scl && clean.scl && st.prev.sda && !clean.sda;
		stop_det  = st.prev.scl && clean.scl && !st.prev.sda && clean.sda;
		scl_rise  = !st.prev.scl && clean.scl;
		scl_fall  = st.prev.scl && !clean.scl;
		sda_rise  = !st.prev.sda && clean.sda;
		next_st = st;
		next_st.sync1.scl = scl_in;
		next_st.sync1.sda = sda_in;
		next_st.sync2 = st.sync1;
		next_st.prev = clean;
		next_st.wr.we = 1'b0;
		// commit on the next sda rising edge, stop or start, whatever the last ack was
		if (st.wr_pend && (sda_rise || stop_det || start_det)) begin // R9 R11
			next_st.wr.we   = 1'b1;
			next_st.wr.addr = st.wr_addr;
			next_st.wr.data = st.wr_data;
			next_st.wr_pend = 1'b0;
		end
		if (stop_det) begin
			next_st.phase   = ST_IDLE; // R19
			next_st.hs      = 1'b0; // R5
			next_st.sda_o   = 1'b1;
			next_st.ack_drv = 1'b0;
			// pointer deliberately untouched R16
		end else if (start_det) begin // R12
			next_st.phase   = ST_ADDR;
			next_st.bitn    = 4'h0;
			next_st.sda_o   = 1'b1;
			next_st.ack_drv = 1'b0;
		end else if (st.phase != ST_IDLE) begin
			if (scl_rise && !st.ack_drv && st.bitn < 4'h8) begin
				next_st.shreg = {st.shreg[6:0], clean.sda}; // R17
				next_st.bitn  = st.bitn + 4'h1;
			end else if (scl_rise && st.bitn == 4'h8 && st.phase == ST_MACK) begin
				if (clean.sda)
					next_st.phase = ST_IDLE; // R15
				else
					next_st.phase = ST_RDATA;
			end else if (scl_fall && st.bitn == 4'h8 && !st.ack_drv) begin
				next_st.sda_o = 1'b1;
				case (st.phase)
				ST_ADDR: begin
					if (st.shreg[7:1] == `SLAVE_ADDR) begin // R1
						next_st.sda_o   = 1'b0;
						next_st.ack_drv = 1'b1;
						next_st.rd      = st.shreg[0];
					end else if (st.shreg == `GENERAL_CALL) // R3
						next_st.phase = ST_IDLE;
					else if (is_hs_code(st.shreg)) begin
						next_st.hs    = 1'b1; // R6 R7
						next_st.phase = ST_IDLE;
					end else
						next_st.phase = ST_IDLE; // R19
				end
				ST_PTR, ST_WDATA: begin
					next_st.sda_o   = 1'b0; // R8 R18 R10
					next_st.ack_drv = 1'b1;
				end
				ST_RDATA: begin
					next_st.phase = ST_MACK; // R14
					next_st.ptr   = st.ptr + 8'h01; // R20
				end
				default: next_st.phase = ST_IDLE;
				endcase
			end else if (scl_fall && st.ack_drv) begin
				next_st.ack_drv = 1'b0;
				next_st.bitn    = 4'h0;
				next_st.sda_o   = 1'b1;
				case (st.phase)
				ST_ADDR: begin
					if (st.rd) begin
						next_st.phase = ST_RDATA; // R13
						next_st.shreg = reg_rd_data;
						next_st.sda_o = reg_rd_data[7];
					end else
						next_st.phase = ST_PTR;
				end
				ST_PTR: begin
					next_st.ptr   = st.shreg;
					next_st.phase = ST_WDATA;
				end
				ST_WDATA: begin
					next_st.wr_pend = 1'b1;
					next_st.wr_addr = st.ptr;
					next_st.wr_data = st.shreg;
					next_st.ptr     = st.ptr + 8'h01; // R20
				end
				default: next_st.phase = ST_IDLE;
				endcase
			end else if (scl_fall && st.phase == ST_RDATA && st.bitn < 4'h8) begin
				next_st.sda_o = st.shreg[7 - st.bitn[2:0]];
			end
			// read byte done on falling edge: bit count stays at 8
			if (scl_fall && st.phase == ST_RDATA && st.bitn == 4'h8
			    && next_st.phase == ST_RDATA && !st.ack_drv) begin
				next_st.bitn = 4'h8;
			end
		end
		if (st.phase == ST_RDATA && scl_rise && st.bitn < 4'h8)
			next_st.shreg = st.shreg; // transmitter keeps its byte
		if (st.phase == ST_MACK && scl_rise && !clean.sda) begin
			next_st.bitn  = 4'h0;
			next_st.shreg = reg_rd_data; // R15
		end
		if (st.phase == ST_RDATA && st.bitn == 4'h0 && st.prev.scl == 1'b0
		    && st.sda_o != st.shreg[7] && !st.ack_drv)
			next_st.sda_o = st.shreg[7];
		if (st.phase == ST_RDATA && scl_rise && st.bitn < 4'h8)
			next_st.bitn = st.bitn + 4'h1;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st         <= '0;
			st.sync1   <= '{scl: 1'b1, sda: 1'b1};
			st.sync2   <= '{scl: 1'b1, sda: 1'b1};
			st.prev    <= '{scl: 1'b1, sda: 1'b1};
			st.phase   <= ST_IDLE;
			st.ptr     <= `PTR_RESET;
			st.sda_o   <= 1'b1;
		end else
			st <= next_st;
	end

	always_comb begin
		scl_out     = 1'b1;
		scl_oe      = 1'b0; // R2
		sda_out     = 1'b0;
		sda_oe      = !st.sda_o;
		reg_wr      = st.wr;
		reg_rd_addr = st.ptr;
		hs_mode     = st.hs;
	end

	property p_no_stretch;
		@(posedge mclk) disable iff (rst) !scl_oe;
	endproperty
	a_no_stretch: assert property (p_no_stretch) // R2
		else $error("scl driven");

	property p_stop_slow;
		@(posedge mclk) disable iff (rst) stop_det |=> !hs_mode;
	endproperty
	a_stop_slow: assert property (p_stop_slow) // R5
		else $error("hs kept after stop");

	property p_stop_ptr;
		@(posedge mclk) disable iff (rst)
			stop_det && !st.wr_pend |=> $stable(reg_rd_addr);
	endproperty
	a_stop_ptr: assert property (p_stop_ptr) // R16
		else $error("pointer moved on stop");

	property p_idle_quiet;
		@(posedge mclk) disable iff (rst)
			st.phase == ST_IDLE && !start_det |=> st.phase == ST_IDLE;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) // R19
		else $error("left idle without start");

	property p_write_once;
		@(posedge mclk) disable iff (rst) reg_wr.we |=> !reg_wr.we;
	endproperty
	a_write_once: assert property (p_write_once) // R9
		else $error("double commit");

	// general call must end the frame with sda released
	property p_gc_nack;
		@(posedge mclk) disable iff (rst)
			st.phase == ST_ADDR && scl_fall && st.bitn == 4'h8
			&& !st.ack_drv && st.shreg == `GENERAL_CALL |=> !sda_oe;
	endproperty
	a_gc_nack: assert property (p_gc_nack) // R3
		else $error("general call acked");

	property p_hs_entry;
		@(posedge mclk) disable iff (rst)
			st.phase == ST_ADDR && scl_fall && st.bitn == 4'h8
			&& !st.ack_drv && is_hs_code(st.shreg) |=> hs_mode && !sda_oe;
	endproperty
	a_hs_entry: assert property (p_hs_entry) // R6
		else $error("hs code not taken");
endmodule : i2c_reg_slave

// File: bench/i2c_master_model.sv
// behavioural two-wire bus master driving scl/sda as open-drain levels
// assumes the bench resolves the shared sda wire with a pull-up
`timescale 1ns/100ps
module i2c_master_model (
	input  wire logic mclk,
	input  wire logic sda_bus,
	output      logic scl,
	output      logic sda
);
	int lo = 62;
	int hi = 63;

	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end

	task automatic wait_n(input int n);
		repeat (n) @(negedge mclk);
	endtask : wait_n

	// also serves as repeated start from a low clock
	task automatic start();
		sda = 1'b1;
		wait_n(lo);
		scl = 1'b1;
		wait_n(hi);
		sda = 1'b0;
		wait_n(hi);
		scl = 1'b0;
		wait_n(2);
	endtask : start

	task automatic stop();
		sda = 1'b0;
		wait_n(lo);
		scl = 1'b1;
		wait_n(hi);
		sda = 1'b1;
		wait_n(hi);
	endtask : stop

	// sampled late in the high phase; slave data moves on scl fall
	task automatic clk_bit(input logic b, output logic got);
		sda = b;
		wait_n(lo - 2);
		scl = 1'b1;
		wait_n(hi);
		got = sda_bus;
		scl = 1'b0;
		wait_n(2);
	endtask : clk_bit

	// ack_in 0 acks a read byte, 1 releases sda for the slave
	task automatic xfer(input logic [7:0] d, input logic ack_in,
			output logic [7:0] q, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], q[i]);
		end
		clk_bit(ack_in, a);
		ack = ~a;
	endtask : xfer
endmodule : i2c_master_model

// File: bench/test_i2c_slave_register_access.sv
// self-checking bench: master model on the bus, register array behind
// assumes the slave sees a pull-up on both lines
`timescale 1ns/100ps
module test_i2c_slave_register_access;
	import i2c_slave_pkg::*;
	typedef struct packed {logic [7:0] addr; logic ack;} row_t;
	logic       mclk, rst, m_scl, m_sda, scl_out, scl_oe;
	logic       sda_out, sda_oe, hs_mode, a, scl_drv;
	reg_wr_t    reg_wr;
	logic [7:0] reg_rd_addr, q;
	logic [7:0] regs [256];
	int         n_fail = 0, n_checks = 0, cyc = 0;
	row_t       rows [5] = '{'{8'h90, 1'b1}, '{8'h92, 1'b0},
		'{8'h00, 1'b0}, '{8'h20, 1'b0}, '{8'h48, 1'b0}};
	wire logic scl_bus = m_scl & ~(scl_oe & ~scl_out);
	wire logic sda_bus = m_sda & ~(sda_oe & ~sda_out);
	wire logic [7:0] rd_data = regs[reg_rd_addr];

	i2c_reg_slave i_dut (.mclk(mclk), .rst(rst), .scl_in(scl_bus),
		.sda_in(sda_bus), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_out(sda_out), .sda_oe(sda_oe), .reg_wr(reg_wr),
		.reg_rd_addr(reg_rd_addr), .reg_rd_data(rd_data),
		.hs_mode(hs_mode));
	i2c_master_model i_master (.mclk(mclk), .sda_bus(sda_bus),
		.scl(m_scl), .sda(m_sda));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		if (reg_wr.we === 1'b1)
			regs[reg_wr.addr] <= reg_wr.data;
		if (!rst && scl_oe !== 1'b0)
			scl_drv <= 1'b1;
		cyc++;
		if (cyc == 80000) begin
			n_fail++;
			final_report();
		end
	end

	task automatic check(input string what, input logic [7:0] exp,
			input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask : check

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report

	initial begin
		rst = 1'b1;
		scl_drv = 1'b0;
		foreach (regs[i]) regs[i] = 8'h00;
		repeat (8) @(negedge mclk);
		rst = 1'b0;
		check("hs_mode", 8'h00, {7'h0, hs_mode});
		check("sda_oe", 8'h00, {7'h0, sda_oe});
		check("pointer", 8'h00, reg_rd_addr);
		repeat (8) @(negedge mclk);
		$display("test reset done");
		foreach (rows[i]) begin
			i_master.start();
			i_master.xfer(rows[i].addr, 1'b1, q, a);
			check("addr ack", {7'h0, rows[i].ack}, {7'h0, a});
			if (!rows[i].ack) begin
				// unselected slave must not wake on a bare byte
				i_master.xfer(8'h90, 1'b1, q, a);
				check("ignored ack", 8'h00, {7'h0, a});
			end
			i_master.stop();
		end
		$display("test addresses done");
		i_master.start();
		i_master.xfer(8'h90, 1'b1, q, a);
		check("wr addr ack", 8'h01, {7'h0, a});
		i_master.xfer(8'hfe, 1'b1, q, a);
		check("ptr ack", 8'h01, {7'h0, a});
		i_master.xfer(8'ha5, 1'b1, q, a);
		check("data ack", 8'h01, {7'h0, a});
		i_master.xfer(8'h3c, 1'b1, q, a);
		check("last ack", 8'h01, {7'h0, a});
		i_master.stop();
		repeat (4) @(negedge mclk);
		check("reg fe", 8'ha5, regs[8'hfe]);
		check("reg ff", 8'h3c, regs[8'hff]);
		check("pointer", 8'h00, reg_rd_addr);
		$display("test write done");
		i_master.start();
		i_master.xfer(8'h90, 1'b1, q, a);
		i_master.xfer(8'hfe, 1'b1, q, a);
		i_master.start();
		i_master.xfer(8'h91, 1'b1, q, a);
		check("rd addr ack", 8'h01, {7'h0, a});
		i_master.xfer(8'hff, 1'b0, q, a);
		check("rd byte 0", 8'ha5, q);
		i_master.xfer(8'hff, 1'b1, q, a);
		check("rd byte 1", 8'h3c, q);
		i_master.stop();
		check("released", 8'h00, {7'h0, sda_oe});
		$display("test read done");
		i_master.start();
		i_master.xfer(8'h0b, 1'b1, q, a);
		check("hs code ack", 8'h00, {7'h0, a});
		check("hs_mode", 8'h01, {7'h0, hs_mode});
		// 128 ns bus clock once the fast filters are on
		i_master.lo = 10;
		i_master.hi = 6;
		i_master.start();
		i_master.xfer(8'h90, 1'b1, q, a);
		i_master.xfer(8'hff, 1'b1, q, a);
		i_master.start();
		check("hs after sr", 8'h01, {7'h0, hs_mode});
		i_master.xfer(8'h91, 1'b1, q, a);
		i_master.xfer(8'hff, 1'b1, q, a);
		check("hs rd byte", 8'h3c, q);
		i_master.stop();
		repeat (8) @(negedge mclk);
		check("hs cleared", 8'h00, {7'h0, hs_mode});
		check("scl driven", 8'h00, {7'h0, scl_drv});
		$display("test high speed done");
		final_report();
	end
endmodule : test_i2c_slave_register_access
